//--- sim/ssr_master_model.sv
// External serial master model driving clock and data into the receiver
`default_nettype none
module ssr_master_model (
   output logic sck,
   output logic sdo
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      sck = 1'b0;
      sdo = 1'b0;
   end
   // Clock stands low between frames; data moves only while it is low
   task automatic send(input logic [7:0] b, input logic msb_first);
      int i;
      #37;
      for (i = 0; i < 8; i++) begin
         sdo = msb_first ? b[7-i] : b[i];
         #400 sck = 1'b1;
         #400 sck = 1'b0;
      end
      // Released line must not show the last bit
      sdo = ~sdo;
   endtask : send
endmodule : ssr_master_model
`default_nettype wire

//--- sim/ssr_receiver_monitor.sv
// Port-level checker for the serial receiver
`default_nettype none
module ssr_receiver_monitor (
   input wire logic        clk,
   input wire logic        srst,
   input wire logic [11:0] paddr,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        serial_clock_pin,
   input wire logic        serial_data_in_pin,
   input wire logic        irq
);
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   logic       sck_q;
   logic [3:0] since_q;
   // Cycles since the last raw clock rise, saturating
   always_ff @(posedge clk) begin
      sck_q   <= serial_clock_pin;
      since_q <= srst ? 4'hf : (serial_clock_pin && !sck_q) ? 4'h0
                 : (since_q == 4'hf) ? since_q : since_q + 4'h1;
   end
   a_ready_always: assert property (psel |-> pready) else $error("pready low");
   a_err_access: assert property (pslverr |-> psel && penable) else $error("stray pslverr");
   a_err_unmapped: assert property (psel && penable && paddr[11:5] != 7'h00 && paddr[1:0] == 2'b00
      |-> pslverr && (pwrite || prdata == 32'h0)) else $error("unmapped not refused");
   a_ok_mapped: assert property (psel && penable && paddr[11:5] == 7'h00 && paddr[1:0] == 2'b00
      |-> !pslverr) else $error("mapped refused");
   a_reset_quiet: assert property ($fell(srst) |-> !irq && prdata == 32'h0) else $error("reset");
   a_prdata_hold: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
      else $error("prdata moved");
   a_irq_cause: assert property ($rose(irq) && !$past(psel && penable && pwrite)
      |-> since_q <= 4'hc) else $error("irq without byte");
   a_clear_empties: assert property ((psel && penable && pwrite && paddr == ssr_pkg::OFF_FCTRL
      && pwdata[1]) ##3 (psel && penable && !pwrite && paddr == ssr_pkg::OFF_FSTAT)
      |-> prdata[7:3] == 5'h00) else $error("clear left bytes");
endmodule : ssr_receiver_monitor
bind ssr_receiver ssr_receiver_monitor u_mon (.clk, .srst, .paddr, .psel, .penable, .pwrite,
   .pwdata, .prdata, .pready, .pslverr, .serial_clock_pin, .serial_data_in_pin, .irq);
`default_nettype wire

//--- sim/test_ssr_receiver.sv
// Self-checking bench for the serial receiver
`default_nettype none
module test_ssr_receiver;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, seed = 32'h131bb, prdata;
   logic        pready, pslverr, irq, serial_clock_pin, serial_data_in_pin;
   logic [31:0] exp_q[$];
   logic [7:0]  b[8];
   int          fails = 0, check_count = 0, i;
   ssr_receiver dut (.clk, .srst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
      .pslverr, .serial_clock_pin, .serial_data_in_pin, .irq);
   ssr_master_model m (.sck(serial_clock_pin), .sdo(serial_data_in_pin));
   always #50 clk = ~clk;
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction : xs
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         fails++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
      psel <= 1'b1; paddr <= a; pwrite <= w; pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      // Waits for the answer; only the watchdog ends a hung access
      do @(posedge clk); while (pready !== 1'b1);
      psel <= 1'b0; penable <= 1'b0;
      @(posedge clk);
   endtask : apb
   task automatic wr(input logic [11:0] a, input logic [31:0] d); apb(a, 1'b1, d); endtask : wr
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      apb(a, 1'b0, 32'h0);
   endtask : rd
   task automatic byte_in(input logic [7:0] v, input logic msb);
      m.send(v, msb);
      repeat (8) @(posedge clk);
   endtask : byte_in
   // Result watcher pairs each completed read with the oldest note
   always @(posedge clk)
      if (psel && penable && pready && !pwrite && exp_q.size() > 0) check(prdata, exp_q.pop_front());
   task automatic conclude();
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : conclude
   initial begin
      #2000000;
      fails++;
      conclude();
   end
   initial begin
      repeat (3) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      rd(ssr_pkg::OFF_STOP, 32'h1);
      rd(ssr_pkg::OFF_CTRL, 32'h0);
      rd(ssr_pkg::OFF_FCTRL, 32'h80);
      rd(12'h020, 32'h0);
      byte_in(8'ha5, 1'b0);
      rd(ssr_pkg::OFF_FSTAT, 32'h4);
      $display("test reset done");
      wr(ssr_pkg::OFF_CTRL, 32'h0);
      wr(ssr_pkg::OFF_STOP, 32'h0);
      wr(ssr_pkg::OFF_FCTRL, 32'h83);
      wr(ssr_pkg::OFF_IRQ_EN, 32'h1);
      wr(ssr_pkg::OFF_CTRL, 32'h2a);
      for (i = 0; i < 8; i++) begin
         seed = xs(seed);
         b[i] = seed[7:0];
         byte_in(b[i], 1'b0);
         if (i == 6) check({31'h0, irq}, 32'h0);
      end
      rd(ssr_pkg::OFF_FSTAT, 32'h41);
      check({31'h0, irq}, 32'h1);
      for (i = 0; i < 8; i++) rd(ssr_pkg::OFF_DATA, {24'h0, b[i]});
      rd(ssr_pkg::OFF_IRQ_ST, 32'h1);
      wr(ssr_pkg::OFF_IRQ_CL, 32'h1);
      check({31'h0, irq}, 32'h0);
      $display("test threshold done");
      for (i = 0; i < 17; i++) begin
         seed = xs(seed);
         byte_in(seed[7:0], 1'b0);
      end
      rd(ssr_pkg::OFF_FSTAT, 32'h83);
      rd(ssr_pkg::OFF_IRQ_ST, 32'h3);
      wr(ssr_pkg::OFF_IRQ_EN, 32'h0);
      check({31'h0, irq}, 32'h0);
      wr(ssr_pkg::OFF_IRQ_EN, 32'h1);
      check({31'h0, irq}, 32'h1);
      wr(ssr_pkg::OFF_FCTRL, 32'h83);
      rd(ssr_pkg::OFF_FSTAT, 32'h4);
      wr(ssr_pkg::OFF_IRQ_CL, 32'h3);
      check({31'h0, irq}, 32'h0);
      $display("test overrun done");
      wr(ssr_pkg::OFF_CTRL, 32'h6a);
      seed = xs(seed);
      byte_in(seed[7:0], 1'b1);
      rd(ssr_pkg::OFF_DATA, {24'h0, seed[7:0]});
      wr(ssr_pkg::OFF_FCTRL, 32'h80);
      byte_in(8'h3c, 1'b1);
      byte_in(8'hc3, 1'b1);
      rd(ssr_pkg::OFF_IRQ_ST, 32'h3);
      rd(ssr_pkg::OFF_DATA, 32'h3c);
      $display("test order and single done");
      wr(ssr_pkg::OFF_CTRL, 32'h0);
      byte_in(8'h5a, 1'b0);
      rd(ssr_pkg::OFF_FSTAT, 32'h4);
      $display("test end of reception done");
      conclude();
   end
endmodule : test_ssr_receiver
`default_nettype wire

//--- verilog/ssr_fifo.sv
// Receive FIFO with count and synchronous clear
`default_nettype none
module ssr_fifo (
   input  wire logic                      clk,
   input  wire logic                      srst,
   input  wire logic                      clear,
   input  wire logic                      push,
   input  wire logic [ssr_pkg::DATA_W-1:0] wdata,
   input  wire logic                      pop,
   output logic      [ssr_pkg::DATA_W-1:0] rdata,
   output logic      [ssr_pkg::CNT_W-1:0]  count,
   output logic                           full,
   output logic                           empty
);
   logic [ssr_pkg::DATA_W-1:0] mem [ssr_pkg::FIFO_DEPTH];
   logic [ssr_pkg::PTR_W-1:0]  wp_q;
   logic [ssr_pkg::PTR_W-1:0]  rp_q;
   logic [ssr_pkg::CNT_W-1:0]  cnt_q;
   wire                        do_push = push & ~full;
   wire                        do_pop  = pop & ~empty;

   assign full  = (cnt_q == ssr_pkg::CNT_W'(ssr_pkg::FIFO_DEPTH));
   assign empty = (cnt_q == '0);
   assign count = cnt_q;
   assign rdata = mem[rp_q];

   always_ff @(posedge clk) begin
      if (do_push) begin
         mem[wp_q] <= wdata;
      end
   end

   always_ff @(posedge clk) begin
      if (srst || clear) begin
         wp_q  <= '0;
         rp_q  <= '0;
         cnt_q <= '0;
      end else begin
         wp_q  <= wp_q + ssr_pkg::PTR_W'(do_push);
         rp_q  <= rp_q + ssr_pkg::PTR_W'(do_pop);
         cnt_q <= cnt_q + ssr_pkg::CNT_W'(do_push) - ssr_pkg::CNT_W'(do_pop);
      end
   end
endmodule : ssr_fifo
`default_nettype wire

//--- verilog/ssr_pkg.sv
// Package of register map, fields and constants for the sync serial receiver
`default_nettype none
package ssr_pkg;
   localparam int unsigned ADDR_W = 12;
   // Register byte offsets
   localparam logic [11:0] OFF_STOP   = 12'h000;
   localparam logic [11:0] OFF_CTRL   = 12'h004;
   localparam logic [11:0] OFF_FCTRL  = 12'h008;
   localparam logic [11:0] OFF_FSTAT  = 12'h00c;
   localparam logic [11:0] OFF_DATA   = 12'h010;
   localparam logic [11:0] OFF_IRQ_ST = 12'h014;
   localparam logic [11:0] OFF_IRQ_EN = 12'h018;
   localparam logic [11:0] OFF_IRQ_CL = 12'h01c;
   // Control register fields
   localparam int unsigned CTRL_TX_IRQ_EN     = 0;
   localparam int unsigned CTRL_RX_IRQ_EN     = 1;
   localparam int unsigned CTRL_TX_EN         = 2;
   localparam int unsigned CTRL_RX_EN         = 3;
   localparam int unsigned CTRL_TX_END_IRQ_EN = 4;
   localparam int unsigned CTRL_SYNC_MODE     = 5;
   localparam int unsigned CTRL_BIT_DIR       = 6;
   localparam int unsigned CTRL_W             = 7;
   // FIFO control fields
   localparam int unsigned FC_MODE   = 0;
   localparam int unsigned FC_CLEAR  = 1;
   localparam int unsigned FC_THR_LO = 4;
   localparam int unsigned THR_W     = 4;
   localparam logic [3:0]  THR_RST   = 4'h8;
   // Interrupt status bits
   localparam int unsigned IRQ_FULL    = 0;
   localparam int unsigned IRQ_OVERRUN = 1;
   localparam int unsigned IRQ_W       = 2;
   // FIFO geometry
   localparam int unsigned FIFO_DEPTH = 16;
   localparam int unsigned PTR_W      = 4;
   localparam int unsigned CNT_W      = 5;
   localparam int unsigned DATA_W     = 8;
   localparam logic [2:0]  LAST_BIT   = 3'h7;
   typedef enum logic [1:0] {
      SSR_STOPPED = 2'b00,
      SSR_IDLE    = 2'b01,
      SSR_SHIFT   = 2'b10
   } ssr_state_t;
endpackage : ssr_pkg
`default_nettype wire

//--- verilog/ssr_receiver.sv
// Clock-synchronous slave receiver with receive FIFO and APB registers
`default_nettype none
module ssr_receiver (
   input  wire logic        clk,
   input  wire logic        srst,
   input  wire logic [11:0] paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        serial_clock_pin,
   input  wire logic        serial_data_in_pin,
   output logic             irq
);
   // Register state
   logic                             stop_q;
   logic [ssr_pkg::CTRL_W-1:0]       ctrl_q;
   logic                             fmode_q;
   logic [ssr_pkg::THR_W-1:0]        thr_q;
   logic [ssr_pkg::IRQ_W-1:0]        ist_q;
   logic [ssr_pkg::IRQ_W-1:0]        ien_q;
   logic [ssr_pkg::DATA_W-1:0]       single_q;
   logic                             single_v_q;
   logic [31:0]                      prdata_q;
   logic                             pop_ok_q;
   // Pin synchronisers: bit 0 carries the clock pin, bit 1 the data pin
   wire  [1:0]                       pin_raw = {serial_data_in_pin, serial_clock_pin};
   logic [1:0]                       pin_s0_q;
   logic [1:0]                       pin_s1_q;
   logic                             sck_prev_q;
   // Shifter
   ssr_pkg::ssr_state_t              st_q;
   logic [ssr_pkg::DATA_W-1:0]       shf_q;
   logic [2:0]                       bcnt_q;
   logic                             byte_v_q;
   logic [ssr_pkg::DATA_W-1:0]       byte_q;

   // Bus decode
   wire        acc      = psel & penable;
   wire        wr       = acc & pwrite;
   wire        rd       = acc & ~pwrite;
   wire        sel_stop = (paddr == ssr_pkg::OFF_STOP);
   wire        sel_ctrl = (paddr == ssr_pkg::OFF_CTRL);
   wire        sel_fc   = (paddr == ssr_pkg::OFF_FCTRL);
   wire        sel_fs   = (paddr == ssr_pkg::OFF_FSTAT);
   wire        sel_dat  = (paddr == ssr_pkg::OFF_DATA);
   wire        sel_ist  = (paddr == ssr_pkg::OFF_IRQ_ST);
   wire        sel_ien  = (paddr == ssr_pkg::OFF_IRQ_EN);
   wire        sel_icl  = (paddr == ssr_pkg::OFF_IRQ_CL);
   wire        mapped   = sel_stop | sel_ctrl | sel_fc | sel_fs | sel_dat | sel_ist
                          | sel_ien | sel_icl;

   // Zero wait states; unmapped accesses are refused, never stalled
   assign pready  = 1'b1;
   assign pslverr = acc & ~mapped;
   assign prdata  = prdata_q;

   // Channel operating state
   wire        running  = ~stop_q;
   wire        sync_on  = ctrl_q[ssr_pkg::CTRL_SYNC_MODE];
   wire        rx_on    = running & sync_on & ctrl_q[ssr_pkg::CTRL_RX_EN];
   wire        msb_first = ctrl_q[ssr_pkg::CTRL_BIT_DIR];
   wire        fifo_clr = wr & sel_fc & pwdata[ssr_pkg::FC_CLEAR];

   // Serial clock edge on the synchronised pin only
   wire        sck_rise = pin_s1_q[0] & ~sck_prev_q;
   wire        sdi      = pin_s1_q[1];

   // FIFO
   logic [ssr_pkg::DATA_W-1:0] f_rdata;
   logic [ssr_pkg::CNT_W-1:0]  f_count;
   logic                       f_full;
   logic                       f_empty;
   wire        push     = byte_v_q & fmode_q;
   // A pop needs data seen at setup, so a byte landing mid-read stays queued
   wire        pop_f    = rd & sel_dat & fmode_q & pop_ok_q;
   wire        pop_s    = rd & sel_dat & ~fmode_q & pop_ok_q;

   ssr_fifo u_fifo (
      .clk   (clk),
      .srst  (srst),
      .clear (fifo_clr),
      .push  (push),
      .wdata (byte_q),
      .pop   (pop_f),
      .rdata (f_rdata),
      .count (f_count),
      .full  (f_full),
      .empty (f_empty)
   );

   // Receive full flag: threshold reached, or a byte held in single mode
   // Threshold zero never reports full
   wire        thr_hit  = (f_count >= {1'b0, thr_q}) & (thr_q != '0);
   wire        rx_full  = fmode_q ? thr_hit : single_v_q;
   wire        ovr_ev   = byte_v_q & (fmode_q ? f_full : single_v_q);
   // Only full and overrun feed the status; no parity or framing sources exist
   wire [ssr_pkg::IRQ_W-1:0] ev;
   assign ev[ssr_pkg::IRQ_FULL]    = rx_full;
   assign ev[ssr_pkg::IRQ_OVERRUN] = ovr_ev;
   wire [ssr_pkg::IRQ_W-1:0] clr_bits = (wr & sel_icl) ? pwdata[ssr_pkg::IRQ_W-1:0] : '0;
   wire        rx_irq_gate = ctrl_q[ssr_pkg::CTRL_RX_IRQ_EN];
   assign irq = rx_irq_gate & |(ist_q & ien_q);

   // Bit assembly
   wire [ssr_pkg::DATA_W-1:0] shf_d = msb_first ? {shf_q[ssr_pkg::DATA_W-2:0], sdi}
                                                : {sdi, shf_q[ssr_pkg::DATA_W-1:1]};
   wire        last_bit = (bcnt_q == ssr_pkg::LAST_BIT);

   // Read mux
   wire [31:0] rd_fs = {{(32-ssr_pkg::CNT_W-3){1'b0}}, f_count, f_empty, f_full, rx_full};
   wire [31:0] rd_fc = {{(32-ssr_pkg::FC_THR_LO-ssr_pkg::THR_W){1'b0}}, thr_q,
                        {(ssr_pkg::FC_THR_LO-1){1'b0}}, fmode_q};
   wire [31:0] rd_dt = {24'h000000, fmode_q ? f_rdata : single_q};
   wire [31:0] rd_mux = sel_stop ? {31'h00000000, stop_q} :
                        sel_ctrl ? {{(32-ssr_pkg::CTRL_W){1'b0}}, ctrl_q} :
                        sel_fc   ? rd_fc :
                        sel_fs   ? rd_fs :
                        sel_dat  ? rd_dt :
                        sel_ist  ? {{(32-ssr_pkg::IRQ_W){1'b0}}, ist_q} :
                        sel_ien  ? {{(32-ssr_pkg::IRQ_W){1'b0}}, ien_q} :
                                   32'h00000000;

   always_ff @(posedge clk) begin
      if (srst) begin
         stop_q <= 1'b1;
      end else if (wr && sel_stop) begin
         stop_q <= pwdata[0];
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         ctrl_q <= '0;
      end else if (wr && sel_ctrl) begin
         ctrl_q <= pwdata[ssr_pkg::CTRL_W-1:0];
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         fmode_q <= 1'b0;
         thr_q   <= ssr_pkg::THR_RST;
      end else if (wr && sel_fc) begin
         fmode_q <= pwdata[ssr_pkg::FC_MODE];
         thr_q   <= pwdata[ssr_pkg::FC_THR_LO +: ssr_pkg::THR_W];
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         ien_q <= '0;
      end else if (wr && sel_ien) begin
         ien_q <= pwdata[ssr_pkg::IRQ_W-1:0];
      end
   end

   // One sticky bit per event; set wins over a clear in the same cycle
   for (genvar g = 0; g < ssr_pkg::IRQ_W; g++) begin : g_status
      always_ff @(posedge clk) begin
         if (srst) begin
            ist_q[g] <= 1'b0;
         end else begin
            ist_q[g] <= (ist_q[g] & ~clr_bits[g]) | ev[g];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         prdata_q <= 32'h00000000;
      end else if (psel && !penable && !pwrite) begin
         prdata_q <= rd_mux;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         pop_ok_q <= 1'b0;
      end else if (psel && !penable && !pwrite) begin
         pop_ok_q <= fmode_q ? ~f_empty : single_v_q;
      end
   end

   // Single-register mode holds one byte; overrun drops the new one
   always_ff @(posedge clk) begin
      if (srst) begin
         single_q   <= '0;
         single_v_q <= 1'b0;
      end else if (byte_v_q && !fmode_q && !single_v_q) begin
         single_q   <= byte_q;
         single_v_q <= 1'b1;
      end else if (pop_s) begin
         single_v_q <= 1'b0;
      end
   end

   for (genvar p = 0; p < 2; p++) begin : g_sync
      always_ff @(posedge clk) begin
         if (srst) begin
            pin_s0_q[p] <= 1'b0;
            pin_s1_q[p] <= 1'b0;
         end else begin
            pin_s0_q[p] <= pin_raw[p];
            pin_s1_q[p] <= pin_s0_q[p];
         end
      end
   end

   // Edge memory resets to the idle low level, so no false edge follows reset
   always_ff @(posedge clk) begin
      if (srst) begin
         sck_prev_q <= 1'b0;
      end else begin
         sck_prev_q <= pin_s1_q[0];
      end
   end

   // Shifter: eight bits on rising serial clock, no handshake lines
   wire        in_frame = (st_q == ssr_pkg::SSR_IDLE) | (st_q == ssr_pkg::SSR_SHIFT);
   wire        bit_take = rx_on & sck_rise & in_frame;
   wire        byte_end = bit_take & (st_q == ssr_pkg::SSR_SHIFT) & last_bit;
   ssr_pkg::ssr_state_t              st_d;

   always_comb begin
      st_d = st_q;
      case (st_q)
         ssr_pkg::SSR_STOPPED: begin
            if (rx_on) begin
               st_d = ssr_pkg::SSR_IDLE;
            end
         end
         ssr_pkg::SSR_IDLE: begin
            if (!rx_on) begin
               st_d = ssr_pkg::SSR_STOPPED;
            end else if (sck_rise) begin
               st_d = ssr_pkg::SSR_SHIFT;
            end
         end
         ssr_pkg::SSR_SHIFT: begin
            if (!rx_on) begin
               st_d = ssr_pkg::SSR_STOPPED;
            end else if (byte_end) begin
               st_d = ssr_pkg::SSR_IDLE;
            end
         end
         default: begin
            st_d = ssr_pkg::SSR_STOPPED;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         st_q <= ssr_pkg::SSR_STOPPED;
      end else begin
         st_q <= st_d;
      end
   end

   // Count restarts whenever the channel stops, so a cut byte is discarded
   always_ff @(posedge clk) begin
      if (srst || st_q == ssr_pkg::SSR_STOPPED) begin
         bcnt_q <= 3'h0;
      end else if (bit_take) begin
         bcnt_q <= bcnt_q + 3'h1;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         shf_q <= '0;
      end else if (bit_take) begin
         shf_q <= shf_d;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         byte_v_q <= 1'b0;
         byte_q   <= '0;
      end else begin
         byte_v_q <= byte_end;
         if (byte_end) begin
            byte_q <= shf_d;
         end
      end
   end
endmodule : ssr_receiver
`default_nettype wire
